//--- frame_sync_generator_tb.sv
`timescale 1ns/1ns
module frame_sync_generator_tb;
	import fsg_pkg::*;
	logic       core_clk = 1'b0;
	logic       srst     = 1'b1;
	logic [7:0] regAddr  = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic       regWr    = 1'b0;
	logic       regRd    = 1'b0;
	logic [6:0] gpioIn   = 7'h00;
	logic [7:0] regRdData;
	logic [3:0] bcPinPort0, bcPinPort1, rx0, rx1;
	logic       syncLevel;
	logic       rdSeen   = 1'b0;
	logic       lastLvl  = 1'b0;
	int         sinceEdge = 0;
	int         n_mismatch = 0;
	int         n_compared = 0;
	int         n;
	logic [7:0] readQ[$];
	int         phaseQ[$];
	logic [15:0] hi, lo;

	always #2 core_clk = ~core_clk;

	fsg_frame_sync i_dut (.core_clk(core_clk), .srst(srst), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.gpioIn(gpioIn), .bcPinPort0(bcPinPort0), .bcPinPort1(bcPinPort1),
		.syncLevel(syncLevel));
	fsg_serializer_model i_ser0 (.core_clk(core_clk), .srst(srst), .bcPin(bcPinPort0),
		.rxGpio(rx0));
	fsg_serializer_model i_ser1 (.core_clk(core_clk), .srst(srst), .bcPin(bcPinPort1),
		.rxGpio(rx1));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		readQ.push_back(exp);
		@(posedge core_clk);
		regRd <= 1'b0;
	endtask

	task automatic wait_edge(output int k);
		logic l;
		l = rx0[0];
		k = 0;
		while (rx0[0] === l && k < 10000) begin
			@(posedge core_clk);
			k++;
		end
		check(16'(k >= 10000), 16'h0, "no edge");
	endtask

	task automatic counts(input logic [15:0] h, input logic [15:0] l);
		wr(FSG_ADDR_HIGH_UP, h[15:8]);
		wr(FSG_ADDR_HIGH_LO, h[7:0]);
		wr(FSG_ADDR_LOW_UP, l[15:8]);
		wr(FSG_ADDR_LOW_LO, l[7:0]);
		rd(FSG_ADDR_HIGH_LO, h[7:0]);
		rd(FSG_ADDR_LOW_LO, l[7:0]);
	endtask

	// Skip the partial first phase, then time two whole phases
	task automatic gen(input logic [7:0] ctl, input int p0, input int p1);
		int k;
		wr(FSG_ADDR_CTL, ctl);
		repeat (4) @(posedge core_clk);
		check(rx0[0], ctl[2], "initial level");
		check(syncLevel, ctl[2], "start level");
		wait_edge(k);
		@(negedge core_clk);
		phaseQ.push_back(p0);
		phaseQ.push_back(p1);
		for (k = 0; phaseQ.size() > 0 && k < 20000; k++) @(posedge core_clk);
		check(16'(phaseQ.size()), 16'h0, "phases seen");
		wr(FSG_ADDR_CTL, 8'h00);
		repeat (4) @(posedge core_clk);
		check(rx0[0], 1'b0, "disabled level");
		check(syncLevel, 1'b0, "idle level");
		$display("test generator ctl %h done", ctl);
	endtask

	// ************************************************************
	// Result monitors
	// ************************************************************
	always @(posedge core_clk) rdSeen <= regRd;
	always @(negedge core_clk) if (rdSeen) check(regRdData, readQ.pop_front(), "read");

	always @(posedge core_clk) begin
		sinceEdge++;
		if (!srst && rx0[0] !== lastLvl) begin
			// Port 0 carries the sync on pins 0..2, port 1 on pins 0..1 only
			check(16'({rx0, rx1}), 16'({1'b0, {3{rx0[0]}}, 2'b00, {2{rx0[0]}}}), "port skew");
			if (phaseQ.size() > 0) check(16'(sinceEdge), 16'(phaseQ.pop_front()), "phase");
			sinceEdge = 0;
			lastLvl = rx0[0];
		end
	end

	initial begin
		repeat (60000) @(posedge core_clk);
		n_mismatch++;
		$display("wrong value at %0t: watchdog expired", $time);
		complete_run();
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		void'($urandom(31));
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		rd(FSG_ADDR_CTL, FSG_RST_CTL);
		rd(FSG_ADDR_HIGH_UP, FSG_RST_COUNT);
		rd(FSG_ADDR_LOW_LO, FSG_RST_COUNT);
		rd(FSG_ADDR_PORT_SEL, FSG_RST_PORT_SEL);
		rd(FSG_ADDR_RATE, {5'h00, FSG_RST_RATE});
		rd(FSG_ADDR_PIN_A, FSG_RST_PIN);
		rd(8'h30, 8'h00);
		$display("test reset values done");
		wr(FSG_ADDR_PORT_SEL, 8'h03);
		wr(FSG_ADDR_PIN_A, 8'hAA);
		rd(FSG_ADDR_PIN_A, 8'hAA);
		// Only port 0 is enabled, so port 1 must keep its pin 2 off the sync
		wr(FSG_ADDR_PORT_SEL, 8'h01);
		wr(FSG_ADDR_PIN_B, 8'h0A);
		rd(FSG_ADDR_PIN_B, 8'h0A);
		hi = 16'($urandom_range(3, 1));
		lo = 16'($urandom_range(3, 1));
		// Reference is nominal, so tick counts need no scaling
		counts(hi, lo);
		gen(8'h01, hi * FSG_FRAME_CYC_50M, lo * FSG_FRAME_CYC_50M);
		gen(8'h05, lo * FSG_FRAME_CYC_50M, hi * FSG_FRAME_CYC_50M);
		gen(8'h03, ((hi + lo) >> 1) * FSG_FRAME_CYC_50M,
			((hi + lo) >> 1) * FSG_FRAME_CYC_50M);
		counts(16'h0001, 16'h0001);
		wr(FSG_ADDR_PORT_SEL, 8'h02);
		wr(FSG_ADDR_RATE, 8'h00);
		rd(FSG_ADDR_RATE, {5'h00, FSG_RATE_50M});
		wr(FSG_ADDR_PORT_SEL, 8'h12);
		rd(FSG_ADDR_RATE, 8'h00);
		rd(FSG_ADDR_PIN_B, 8'h00);
		gen(8'h13, FSG_FRAME_CYC_2M5, FSG_FRAME_CYC_2M5);
		gen(8'h03, FSG_FRAME_CYC_50M, FSG_FRAME_CYC_50M);
		for (int k = 0; k < FSG_EXT_PINS; k++) begin
			wr(FSG_ADDR_CTL, {4'(k) + FSG_SRC_PIN_FIRST, 4'h0});
			gpioIn <= 7'(1 << k);
			wait_edge(n);
			check(16'(n > FSG_FRAME_CYC_50M + 10), 16'h0, "rise skew");
			gpioIn <= ~7'(1 << k);
			wait_edge(n);
			check(16'(n > FSG_FRAME_CYC_50M + 10), 16'h0, "fall skew");
			gpioIn <= 7'h00;
		end
		$display("test external pins done");
		complete_run();
	end
endmodule

//--- fsg_frame_sync.sv
`timescale 1ns/1ns
module fsg_frame_sync
	import fsg_pkg::*;
#(
	parameter int NPINS = FSG_EXT_PINS
) (
	input  wire logic             core_clk,
	input  wire logic             srst,
	input  wire logic [7:0]       regAddr,
	input  wire logic [7:0]       regWrData,
	input  wire logic             regWr,
	input  wire logic             regRd,
	output logic      [7:0]       regRdData,
	input  wire logic [NPINS-1:0] gpioIn,
	output logic      [3:0]       bcPinPort0,
	output logic      [3:0]       bcPinPort1,
	output logic                  syncLevel
);
	// ************************************************************
	// Registers
	// ************************************************************
	logic [7:0]  ctl_r;
	logic [15:0] highCnt_r;
	logic [15:0] lowCnt_r;
	logic [7:0]  portSel_r;
	logic [2:0]  rate_r   [FSG_PORTS];
	logic [7:0]  pinSelA_r[FSG_PORTS];
	logic [7:0]  pinSelB_r[FSG_PORTS];
	logic [7:0]  rdData_nxt;
	logic        rdPort;

	assign rdPort = portSel_r[FSG_PSEL_RD_BIT];

	always_ff @(posedge core_clk) begin
		if (srst) begin
			ctl_r <= FSG_RST_CTL;
			highCnt_r <= {FSG_RST_COUNT, FSG_RST_COUNT};
			lowCnt_r <= {FSG_RST_COUNT, FSG_RST_COUNT};
			portSel_r <= FSG_RST_PORT_SEL;
		end else if (regWr) begin
			unique case (regAddr)
				FSG_ADDR_CTL:      ctl_r <= regWrData;
				FSG_ADDR_HIGH_UP:  highCnt_r[15:8] <= regWrData;
				FSG_ADDR_HIGH_LO:  highCnt_r[7:0] <= regWrData;
				FSG_ADDR_LOW_UP:   lowCnt_r[15:8] <= regWrData;
				FSG_ADDR_LOW_LO:   lowCnt_r[7:0] <= regWrData;
				FSG_ADDR_PORT_SEL: portSel_r <= regWrData;
				default: ;
			endcase
		end
	end

	// Port select bits 1:0 steer writes, so one write can program both ports
	always_ff @(posedge core_clk) begin
		for (int p = 0; p < FSG_PORTS; p++) begin
			if (srst) begin
				rate_r[p] <= FSG_RST_RATE;
				pinSelA_r[p] <= FSG_RST_PIN;
				pinSelB_r[p] <= FSG_RST_PIN;
			end else if (regWr && portSel_r[p]) begin
				if (regAddr == FSG_ADDR_RATE) begin
					rate_r[p] <= regWrData[2:0];
				end
				if (regAddr == FSG_ADDR_PIN_A) begin
					pinSelA_r[p] <= regWrData;
				end
				if (regAddr == FSG_ADDR_PIN_B) begin
					pinSelB_r[p] <= regWrData;
				end
			end
		end
	end

	always_comb begin
		rdData_nxt = 8'h00;
		unique case (regAddr)
			FSG_ADDR_CTL:      rdData_nxt = ctl_r;
			FSG_ADDR_HIGH_UP:  rdData_nxt = highCnt_r[15:8];
			FSG_ADDR_HIGH_LO:  rdData_nxt = highCnt_r[7:0];
			FSG_ADDR_LOW_UP:   rdData_nxt = lowCnt_r[15:8];
			FSG_ADDR_LOW_LO:   rdData_nxt = lowCnt_r[7:0];
			FSG_ADDR_PORT_SEL: rdData_nxt = portSel_r;
			FSG_ADDR_RATE:     rdData_nxt = {5'h00, rate_r[rdPort]};
			FSG_ADDR_PIN_A:    rdData_nxt = pinSelA_r[rdPort];
			FSG_ADDR_PIN_B:    rdData_nxt = pinSelB_r[rdPort];
			default:           rdData_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			regRdData <= 8'h00;
		end else if (regRd) begin
			regRdData <= rdData_nxt;
		end
	end

	// ************************************************************
	// Back-channel frame ticks, one per port
	// ************************************************************
	logic [FSG_PORTS-1:0] tick;
	logic [FSG_TICK_W-1:0] tickCnt_r[FSG_PORTS];

	for (genvar p = 0; p < FSG_PORTS; p++) begin : g_tick
		logic [FSG_TICK_W-1:0] last;
		// Only the 50 Mbps code is characterised; other codes run at 2.5 Mbps
		assign last = (rate_r[p] == FSG_RATE_50M) ?
			FSG_TICK_W'(FSG_FRAME_CYC_50M - 1) : FSG_TICK_W'(FSG_FRAME_CYC_2M5 - 1);
		assign tick[p] = (tickCnt_r[p] >= last);
		always_ff @(posedge core_clk) begin
			if (srst || tick[p]) begin
				tickCnt_r[p] <= '0;
			end else begin
				tickCnt_r[p] <= tickCnt_r[p] + 1'b1;
			end
		end
	end

	// ************************************************************
	// External pin synchroniser
	// ************************************************************
	logic [NPINS-1:0] pinMeta_r;
	logic [NPINS-1:0] pinSync_r;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pinMeta_r <= '0;
			pinSync_r <= '0;
		end else begin
			pinMeta_r <= gpioIn;
			pinSync_r <= pinMeta_r;
		end
	end

	// ************************************************************
	// Sync generator
	// ************************************************************
	logic [3:0]  srcSel;
	logic        genEn;
	logic        genEn_r;
	logic        extMode;
	logic        genTick;
	logic [15:0] halfCnt;
	logic [15:0] nextHigh;
	logic [15:0] nextLow;
	logic [15:0] phaseCnt_r;
	logic        syncLevel_r;
	logic [2:0]  pinIdx;

	assign srcSel = ctl_r[FSG_SRC_LSB +: 4];
	assign genEn = ctl_r[FSG_BIT_ENABLE];
	assign extMode = !genEn && srcSel >= FSG_SRC_PIN_FIRST && srcSel <= FSG_SRC_PIN_LAST;
	assign pinIdx = srcSel[2:0];
	assign genTick = (genEn && srcSel == FSG_SRC_PORT1) ? tick[1] : tick[0];
	// Sum kept at 17 bits so long periods halve without wrapping
	assign halfCnt = 16'(({1'b0, highCnt_r} + {1'b0, lowCnt_r}) >> 1);
	assign nextHigh = ctl_r[FSG_BIT_MODE] ? halfCnt : highCnt_r;
	assign nextLow = ctl_r[FSG_BIT_MODE] ? halfCnt : lowCnt_r;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			genEn_r <= 1'b0;
		end else begin
			genEn_r <= genEn;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			syncLevel_r <= 1'b0;
			phaseCnt_r <= 16'h0000;
		end else if (genEn && !genEn_r) begin
			syncLevel_r <= ctl_r[FSG_BIT_INIT];
			phaseCnt_r <= ctl_r[FSG_BIT_INIT] ? nextHigh : nextLow;
		end else if (genEn) begin
			if (genTick) begin
				// A zero count behaves as one tick so the output never stalls
				if (phaseCnt_r <= 16'h0001) begin
					syncLevel_r <= !syncLevel_r;
					phaseCnt_r <= syncLevel_r ? nextLow : nextHigh;
				end else begin
					phaseCnt_r <= phaseCnt_r - 16'h0001;
				end
			end
		end else if (extMode) begin
			if (tick[0]) begin
				syncLevel_r <= pinSync_r[pinIdx];
			end
		end else begin
			syncLevel_r <= 1'b0;
		end
	end

	assign syncLevel = syncLevel_r;

	// Both ports take one shared register so their copies never drift
	always_ff @(posedge core_clk) begin
		if (srst) begin
			bcPinPort0 <= 4'h0;
			bcPinPort1 <= 4'h0;
		end else begin
			bcPinPort0 <= {pinSelB_r[0][7:4] == FSG_PIN_SRC_SYNC, pinSelB_r[0][3:0] == FSG_PIN_SRC_SYNC,
				pinSelA_r[0][7:4] == FSG_PIN_SRC_SYNC, pinSelA_r[0][3:0] == FSG_PIN_SRC_SYNC}
				& {4{syncLevel_r}};
			bcPinPort1 <= {pinSelB_r[1][7:4] == FSG_PIN_SRC_SYNC, pinSelB_r[1][3:0] == FSG_PIN_SRC_SYNC,
				pinSelA_r[1][7:4] == FSG_PIN_SRC_SYNC, pinSelA_r[1][3:0] == FSG_PIN_SRC_SYNC}
				& {4{syncLevel_r}};
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	int unsigned gapCnt;
	always_ff @(posedge core_clk) begin
		if (srst || tick[0]) begin
			gapCnt <= 0;
		end else begin
			gapCnt <= gapCnt + 1;
		end
	end

	chk_tick_period: assert property (@(posedge core_clk) disable iff (srst)
		tick[0] && $past(tick[0] == 1'b0) && rate_r[0] == FSG_RATE_50M && $stable(rate_r[0])
		|-> gapCnt == FSG_FRAME_CYC_50M - 1)
		else $error("port 0 tick period wrong");
	chk_ext_follow: assert property (@(posedge core_clk) disable iff (srst)
		extMode && tick[0] |=> syncLevel_r == $past(pinSync_r[pinIdx]))
		else $error("external level not carried");
	chk_init_level: assert property (@(posedge core_clk) disable iff (srst)
		genEn && !genEn_r |=> syncLevel_r == $past(ctl_r[FSG_BIT_INIT]))
		else $error("generator start level wrong");
	chk_phase_toggle: assert property (@(posedge core_clk) disable iff (srst)
		genEn && genEn_r && genTick && phaseCnt_r <= 16'h0001 && $stable(ctl_r)
		|=> syncLevel_r != $past(syncLevel_r))
		else $error("phase did not toggle");
	chk_phase_reload: assert property (@(posedge core_clk) disable iff (srst)
		genEn && genEn_r && genTick && phaseCnt_r <= 16'h0001 && !syncLevel_r
		|=> phaseCnt_r == $past(nextHigh))
		else $error("high phase reload wrong");
	chk_level_hold: assert property (@(posedge core_clk) disable iff (srst)
		genEn && genEn_r && !genTick && $past(genEn) |=> $stable(syncLevel_r) or !genEn)
		else $error("level changed between ticks");
	chk_ports_match: assert property (@(posedge core_clk) disable iff (srst)
		pinSelA_r[0][3:0] == FSG_PIN_SRC_SYNC && pinSelA_r[1][3:0] == FSG_PIN_SRC_SYNC
		&& $stable(pinSelA_r[0]) && $stable(pinSelA_r[1]) |=> bcPinPort0[0] == bcPinPort1[0])
		else $error("ports out of step");
	chk_ctl_write: assert property (@(posedge core_clk) disable iff (srst)
		regWr && regAddr == FSG_ADDR_CTL |=> ctl_r == $past(regWrData) ##1 genEn_r == ctl_r[0])
		else $error("control write lost");
	chk_half_duty: assert property (@(posedge core_clk) disable iff (srst)
		genEn && genEn_r && genTick && phaseCnt_r <= 16'h0001 && ctl_r[FSG_BIT_MODE]
		|=> phaseCnt_r == $past(halfCnt))
		else $error("50/50 reload wrong");
	chk_off_low: assert property (@(posedge core_clk) disable iff (srst)
		!genEn && !extMode |=> !syncLevel_r)
		else $error("idle sync not low");

	cov_gen_start: cover property (@(posedge core_clk) disable iff (srst) genEn && !genEn_r);
	cov_toggle: cover property (@(posedge core_clk) disable iff (srst)
		genEn && genTick && phaseCnt_r <= 16'h0001);
	cov_ext_high: cover property (@(posedge core_clk) disable iff (srst) extMode && syncLevel_r);
	cov_port1_tick: cover property (@(posedge core_clk) disable iff (srst)
		genEn && srcSel == FSG_SRC_PORT1 && tick[1]);
endmodule

//--- fsg_pkg.sv
// How it works
// - External mode carries selected pin level to back channel, one frame skew.
// - Both back channels drive the same sync register, updated on one tick.
// - Writing 1 to enable in control register 0x18 starts internal generation.
// - In internal mode source select bits 7:4 pick tick port; 0x0 is port 0.
// - Tick period equals one 30-bit back-channel frame: 600 ns or 12 us.
// - Control bit 1 picks separate high/low durations (0) or 50/50 duty (1).
// - Low phase lasts low count ticks, high phase lasts high count ticks.
// - High and low counts are 16 bits, upper/lower bytes at 0x19..0x1C.
// - Control bit 2 sets the level the generated signal starts from.
// - Once enabled the waveform repeats continuously until disabled.
// - Rate select bits 2:0 at 0x58 give 50 Mbps for 110b, setting tick.
package fsg_pkg;
	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] FSG_ADDR_CTL      = 8'h18;
	localparam logic [7:0] FSG_ADDR_HIGH_UP  = 8'h19;
	localparam logic [7:0] FSG_ADDR_HIGH_LO  = 8'h1A;
	localparam logic [7:0] FSG_ADDR_LOW_UP   = 8'h1B;
	localparam logic [7:0] FSG_ADDR_LOW_LO   = 8'h1C;
	localparam logic [7:0] FSG_ADDR_PORT_SEL = 8'h4C;
	localparam logic [7:0] FSG_ADDR_RATE     = 8'h58;
	localparam logic [7:0] FSG_ADDR_PIN_A    = 8'h6E;
	localparam logic [7:0] FSG_ADDR_PIN_B    = 8'h6F;

	// ************************************************************
	// Field positions and codes
	// ************************************************************
	localparam int         FSG_BIT_ENABLE    = 0;
	localparam int         FSG_BIT_MODE      = 1;
	localparam int         FSG_BIT_INIT      = 2;
	localparam int         FSG_SRC_LSB       = 4;
	localparam int         FSG_PSEL_RD_BIT   = 4;
	localparam logic [3:0] FSG_SRC_PIN_FIRST = 4'h8;
	localparam logic [3:0] FSG_SRC_PIN_LAST  = 4'hE;
	localparam logic [3:0] FSG_SRC_PORT1     = 4'h1;
	localparam logic [3:0] FSG_PIN_SRC_SYNC  = 4'hA;
	localparam logic [2:0] FSG_RATE_50M      = 3'b110;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] FSG_RST_CTL       = 8'h00;
	localparam logic [7:0] FSG_RST_COUNT     = 8'h00;
	localparam logic [7:0] FSG_RST_PORT_SEL  = 8'h01;
	localparam logic [2:0] FSG_RST_RATE      = 3'b110;
	localparam logic [7:0] FSG_RST_PIN       = 8'h00;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int FSG_CLK_NS      = 4;
	localparam int FSG_FRAME_BITS  = 30;
	localparam int FSG_BIT_NS_50M  = 20;
	localparam int FSG_BIT_NS_2M5  = 400;
	localparam int FSG_FRAME_CYC_50M = FSG_FRAME_BITS * FSG_BIT_NS_50M / FSG_CLK_NS;
	localparam int FSG_FRAME_CYC_2M5 = FSG_FRAME_BITS * FSG_BIT_NS_2M5 / FSG_CLK_NS;
	localparam int FSG_TICK_W      = 12;
	localparam int FSG_PORTS       = 2;
	localparam int FSG_EXT_PINS    = 7;
endpackage

//--- fsg_serializer_model.sv
`timescale 1ns/1ns
module fsg_serializer_model (
	input  wire logic       core_clk,
	input  wire logic       srst,
	input  wire logic [3:0] bcPin,
	output logic      [3:0] rxGpio
);
	// Both serializers see the same link delay, so one register stands in for it
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rxGpio <= 4'h0;
		end else begin
			rxGpio <= bcPin;
		end
	end
endmodule
